// file: hbrl_pkg.sv
package hbrl_pkg;
  // ==================================================
  // Register map
  // ==================================================
  localparam logic [11:0] ADDR_CURRENT_LVL = 12'h000; // Percent
  localparam logic [11:0] ADDR_FREQ_LVL = 12'h004; // 0.1 Hz units
  localparam logic [11:0] ADDR_DELAY = 12'h008; // 0.1 s units
  localparam logic [11:0] ADDR_TORQUE_LVL = 12'h00C; // Percent
  localparam logic [11:0] ADDR_COND_SEL = 12'h010; // Condition bits
  localparam logic [11:0] ADDR_CONTROL = 12'h014; // Bit0 vector mode
  localparam logic [11:0] ADDR_STATUS = 12'h018; // Live state
  // ==================================================
  // Fields and limits
  // ==================================================
  localparam int QUICK_BIT = 2; // Current response bit
  localparam int VECTOR_BIT = 0; // Control mode bit
  localparam logic [15:0] CURRENT_MAX = 16'h012C; // 300 percent
  localparam logic [15:0] TORQUE_MAX = 16'h012C; // 300 percent
  localparam logic [15:0] FREQ_MAX = 16'h00FA; // 25.0 Hz
  localparam logic [15:0] DELAY_MAX = 16'h0032; // 5.0 s
  localparam logic [15:0] RST_LEVEL = 16'h0064; // 100 percent
  localparam logic [15:0] RST_FREQ = 16'h0032; // 5.0 Hz
  localparam logic [15:0] RST_DELAY = 16'h0005; // 0.5 s
  localparam logic [7:0] RST_COND = 8'h00; // Slow response
  // ==================================================
  // Timing
  // ==================================================
  localparam int CLK_HZ = 20000000; // CORE_CLK rate
  localparam int TICK_MS = 100; // Delay step, ms
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int FILT_SHIFT = 3; // Slow filter weight 1/8
endpackage

// file: hbrl_cfg_if.sv
`timescale 1ns/1ps
// ==================================================
// Settings carried to the decision core
// ==================================================
interface hbrl_cfg_if;
  logic [15:0] current_lvl; // Percent
  logic [15:0] freq_lvl; // 0.1 Hz
  logic [15:0] torque_lvl; // Percent
  logic [15:0] delay_steps; // 0.1 s
  logic quick; // Quick current response
  logic vector_mode; // Vector control active
  modport src (output current_lvl, freq_lvl, torque_lvl, delay_steps,
               quick, vector_mode);
  modport dst (input current_lvl, freq_lvl, torque_lvl, delay_steps,
               quick, vector_mode);
endinterface

// file: hbrl_decide.sv
`timescale 1ns/1ps
// ==================================================
// Release decision core
// ==================================================
module hbrl_decide #(
  parameter int TICK_CYCLES = hbrl_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  hbrl_cfg_if.dst cfg,
  input wire logic [15:0] current, // Percent, same clock
  input wire logic [15:0] freq, // 0.1 Hz
  input wire logic [15:0] torque, // Percent
  output logic release_q,
  output logic cond_now,
  output logic [15:0] filt_cur
);
  logic [15:0] filt_q, filt_d; // Filtered current
  logic [31:0] tick_q, tick_d; // Cycles within one step
  logic [15:0] step_q, step_d; // Elapsed steps
  logic rel_d;
  logic [15:0] cur_used;
  logic [16:0] diff;

  // Choose current path and evaluate the three conditions
  always_comb begin
    diff = {1'b0, current} - {1'b0, filt_q};
    // Slow path lags the real rise a little
    filt_d = filt_q + 16'(($signed(diff)) >>> hbrl_pkg::FILT_SHIFT);
    if (current == 16'h0000) begin
      filt_d = 16'h0000;
    end
    cur_used = cfg.quick ? current : filt_q;
    cond_now = (cur_used > cfg.current_lvl)
      || (!cfg.vector_mode && freq > cfg.freq_lvl)
      || (cfg.vector_mode && torque > cfg.torque_lvl);
  end

  // Delay timer: restarts whenever no condition holds
  always_comb begin
    tick_d = tick_q;
    step_d = step_q;
    rel_d = release_q;
    if (!cond_now) begin
      tick_d = '0;
      step_d = '0;
      rel_d = 1'b0;
    end else if (step_q >= cfg.delay_steps) begin
      rel_d = 1'b1;
    end else if (tick_q == 32'(TICK_CYCLES - 1)) begin
      tick_d = '0;
      step_d = step_q + 16'h0001;
    end else begin
      tick_d = tick_q + 32'h00000001;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 16'h0000;
      tick_q <= 32'h00000000;
      step_q <= 16'h0000;
      release_q <= 1'b0;
    end else begin
      filt_q <= filt_d;
      tick_q <= tick_d;
      step_q <= step_d;
      release_q <= rel_d;
    end
  end
  assign filt_cur = filt_q;

  chk_release_drop: assert property (@(posedge clk) disable iff (rst)
    !cond_now |=> !release_q) else $error("release kept");
  chk_release_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(release_q) |-> $past(step_q) >= cfg.delay_steps)
    else $error("early release");
  chk_release_hold: assert property (@(posedge clk) disable iff (rst)
    release_q && cond_now |=> release_q) else $error("release lost");
endmodule

// file: hbrl_top.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
// ==================================================
// Brake release logic with APB settings
// ==================================================
module hbrl_top #(
  parameter int TICK_CYCLES = hbrl_pkg::TICK_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] OUT_CURRENT,
  input wire logic [15:0] OUT_FREQ,
  input wire logic [15:0] TORQUE_CMD,
  output logic BRAKE_RELEASE_SIGNAL
);
  hbrl_cfg_if cfg ();
  logic [15:0] cur_q, cur_d, frq_q, frq_d, trq_q, trq_d, dly_q, dly_d;
  logic [7:0] sel_q, sel_d; // Braking condition select
  logic vec_q, vec_d; // Vector mode
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic rel, cond;
  logic [15:0] filt;
  logic setup, wr;

  assign cfg.current_lvl = cur_q;
  assign cfg.freq_lvl = frq_q;
  assign cfg.torque_lvl = trq_q;
  assign cfg.delay_steps = dly_q;
  assign cfg.quick = sel_q[hbrl_pkg::QUICK_BIT];
  assign cfg.vector_mode = vec_q;

  // Settings clamp to their legal ranges on write
  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] mx);
    clamp = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  // Zero-wait APB: answer in the cycle after setup
  always_comb begin
    setup = PSEL && !PENABLE;
    wr = PSEL && PENABLE && PWRITE && rdy_q;
    cur_d = cur_q;
    frq_d = frq_q;
    trq_d = trq_q;
    dly_d = dly_q;
    sel_d = sel_q;
    vec_d = vec_q;
    rd_d = rd_q;
    err_d = 1'b0;
    rdy_d = setup;
    if (setup) begin
      rd_d = 32'h00000000;
      unique case (PADDR)
        hbrl_pkg::ADDR_CURRENT_LVL: rd_d = {16'h0000, cur_q};
        hbrl_pkg::ADDR_FREQ_LVL: rd_d = {16'h0000, frq_q};
        hbrl_pkg::ADDR_DELAY: rd_d = {16'h0000, dly_q};
        hbrl_pkg::ADDR_TORQUE_LVL: rd_d = {16'h0000, trq_q};
        hbrl_pkg::ADDR_COND_SEL: rd_d = {24'h000000, sel_q};
        hbrl_pkg::ADDR_CONTROL: rd_d = {31'h00000000, vec_q};
        hbrl_pkg::ADDR_STATUS: rd_d = {14'h0000, cond, rel, filt};
        default: err_d = 1'b1; // Unmapped
      endcase
    end
    if (wr) begin
      unique case (PADDR)
        hbrl_pkg::ADDR_CURRENT_LVL: cur_d = clamp(PWDATA,
          hbrl_pkg::CURRENT_MAX);
        hbrl_pkg::ADDR_FREQ_LVL: frq_d = clamp(PWDATA,
          hbrl_pkg::FREQ_MAX);
        hbrl_pkg::ADDR_DELAY: dly_d = clamp(PWDATA,
          hbrl_pkg::DELAY_MAX);
        hbrl_pkg::ADDR_TORQUE_LVL: trq_d = clamp(PWDATA,
          hbrl_pkg::TORQUE_MAX);
        hbrl_pkg::ADDR_COND_SEL: sel_d = PWDATA[7:0];
        hbrl_pkg::ADDR_CONTROL: vec_d = PWDATA[hbrl_pkg::VECTOR_BIT];
        default: ;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cur_q <= hbrl_pkg::RST_LEVEL;
      frq_q <= hbrl_pkg::RST_FREQ;
      trq_q <= hbrl_pkg::RST_LEVEL;
      dly_q <= hbrl_pkg::RST_DELAY;
      sel_q <= hbrl_pkg::RST_COND;
      vec_q <= 1'b0;
      rd_q <= 32'h00000000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      BRAKE_RELEASE_SIGNAL <= 1'b0;
    end else begin
      cur_q <= cur_d;
      frq_q <= frq_d;
      trq_q <= trq_d;
      dly_q <= dly_d;
      sel_q <= sel_d;
      vec_q <= vec_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      BRAKE_RELEASE_SIGNAL <= rel;
    end
  end
  assign PRDATA = rd_q;
  assign PREADY = rdy_q;
  assign PSLVERR = err_q;

  hbrl_decide #(.TICK_CYCLES(TICK_CYCLES)) u_decide (
    .clk(CORE_CLK),
    .rst(RESET),
    .cfg(cfg),
    .current(OUT_CURRENT),
    .freq(OUT_FREQ),
    .torque(TORQUE_CMD),
    .release_q(rel),
    .cond_now(cond),
    .filt_cur(filt)
  );

  chk_apb_ready: assert property (@(posedge CORE_CLK) disable iff (RESET)
    PSEL && !PENABLE |=> PREADY) else $error("no ready");
  chk_ready_pulse: assert property (@(posedge CORE_CLK) disable iff (RESET)
    PREADY |=> !PREADY) else $error("ready held");
  chk_brake_follow: assert property (@(posedge CORE_CLK) disable iff (RESET)
    BRAKE_RELEASE_SIGNAL == $past(rel)) else $error("brake lag");
  chk_freq_vector: assert property (@(posedge CORE_CLK) disable iff (RESET)
    vec_q && filt <= cur_q && OUT_CURRENT <= cur_q
    && TORQUE_CMD <= trq_q |-> !cond) else $error("freq in vector");
endmodule

// file: hbrl_brake_model.sv
`timescale 1ns/1ps
// ==================================================
// Spring-applied mechanical brake stand-in
// ==================================================
module hbrl_brake_model (
  input wire logic clk,
  input wire logic release_cmd,
  output logic engaged
);
  // Clamps whenever release is not commanded, fail-safe
  always_ff @(posedge clk) begin
    engaged <= !release_cmd;
  end
endmodule

// file: test_hbrl_top.sv
`timescale 1ns/1ps
// ==================================================
// Bench for brake release logic
// ==================================================
module test_hbrl_top;
  localparam int TK = 10; // Short tick keeps runs brief
  logic CORE_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, BRAKE_RELEASE_SIGNAL, engaged, slv;
  logic [15:0] OUT_CURRENT = 16'h0, OUT_FREQ = 16'h0, TORQUE_CMD = 16'h0;
  int err_count = 0, n_tests = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  hbrl_top #(.TICK_CYCLES(TK)) hbrl_top_i (.CORE_CLK(CORE_CLK),
    .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OUT_CURRENT(OUT_CURRENT), .OUT_FREQ(OUT_FREQ),
    .TORQUE_CMD(TORQUE_CMD),
    .BRAKE_RELEASE_SIGNAL(BRAKE_RELEASE_SIGNAL));
  hbrl_brake_model hbrl_brake_model_i (.clk(CORE_CLK),
    .release_cmd(BRAKE_RELEASE_SIGNAL), .engaged(engaged));
  // ==================================================
  // Helpers
  // ==================================================
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    // Only the watchdog ends a wait that never sees ready
    while (PREADY !== 1'b1) begin
      @(posedge CORE_CLK);
    end
    rd = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge so the next call never reassigns in this time step
    @(posedge CORE_CLK);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, slv}, {31'h0, er});
  endtask
  // Quiet before the delay ends, then expected level
  task rel(input logic e, input int cyc);
    int n;
    n = 0;
    repeat (cyc - 3) @(posedge CORE_CLK);
    chk({31'h0, BRAKE_RELEASE_SIGNAL}, 32'h0);
    while (BRAKE_RELEASE_SIGNAL !== 1'b1 && n < 8) begin
      n++;
      @(posedge CORE_CLK);
    end
    chk({31'h0, BRAKE_RELEASE_SIGNAL}, {31'h0, e});
    @(posedge CORE_CLK);
    chk({31'h0, engaged}, {31'h0, !e});
  endtask
  task rst();
    RESET <= 1'b1;
    OUT_CURRENT <= 16'h0; OUT_FREQ <= 16'h0; TORQUE_CMD <= 16'h0;
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
  endtask
  task results();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==================================================
  // Tests
  // ==================================================
  initial begin
    rst();
    rdc(hbrl_pkg::ADDR_CURRENT_LVL, 32'h64, 1'b0);
    rdc(hbrl_pkg::ADDR_FREQ_LVL, 32'h32, 1'b0);
    rdc(hbrl_pkg::ADDR_DELAY, 32'h5, 1'b0);
    rdc(hbrl_pkg::ADDR_STATUS, 32'h0, 1'b0);
    rdc(12'h020, 32'h0, 1'b1); // Unmapped place refused
    apb(1'b1, hbrl_pkg::ADDR_FREQ_LVL, 32'hFFFF);
    rdc(hbrl_pkg::ADDR_FREQ_LVL, 32'hFA, 1'b0);
    apb(1'b1, hbrl_pkg::ADDR_TORQUE_LVL, 32'h1FF);
    rdc(hbrl_pkg::ADDR_TORQUE_LVL, 32'h12C, 1'b0);
    apb(1'b1, hbrl_pkg::ADDR_DELAY, 32'h40);
    rdc(hbrl_pkg::ADDR_DELAY, 32'h32, 1'b0);
    // Quick current; an equal level breaks the run and restarts it
    apb(1'b1, hbrl_pkg::ADDR_COND_SEL, 32'h4);
    apb(1'b1, hbrl_pkg::ADDR_DELAY, 32'h2);
    OUT_CURRENT <= 16'h65;
    repeat (15) @(posedge CORE_CLK);
    OUT_CURRENT <= 16'h64;
    repeat (2) @(posedge CORE_CLK);
    OUT_CURRENT <= 16'h65;
    rel(1'b1, 2 * TK);
    rst();
    chk({31'h0, BRAKE_RELEASE_SIGNAL}, 32'h0);
    // Frequency counts only in V/f
    apb(1'b1, hbrl_pkg::ADDR_DELAY, 32'h1);
    OUT_FREQ <= 16'h33;
    rel(1'b1, TK);
    rst();
    apb(1'b1, hbrl_pkg::ADDR_CONTROL, 32'h1);
    apb(1'b1, hbrl_pkg::ADDR_DELAY, 32'h1);
    OUT_FREQ <= 16'h33;
    rel(1'b0, TK);
    TORQUE_CMD <= 16'h65;
    rel(1'b1, TK);
    rst();
    TORQUE_CMD <= 16'h12C;
    rel(1'b0, TK);
    // Slow filter lags a current step, quick does not
    apb(1'b1, hbrl_pkg::ADDR_CURRENT_LVL, 32'h96);
    OUT_CURRENT <= 16'hC8;
    apb(1'b0, hbrl_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[17]}, 32'h0);
    apb(1'b1, hbrl_pkg::ADDR_COND_SEL, 32'h4);
    apb(1'b0, hbrl_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[17]}, 32'h1);
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    err_count++;
    results();
  end
endmodule
